// ===== spi_link_master.sv
// far-side master model driving the select pin
`timescale 1ns/1ps
`default_nettype none
module spi_link_master (
   // start and select
   input  wire logic go,
   output logic      link_sel_n
);
   // select falls at frame start, idles high
   initial link_sel_n = 1'b1;
   always @(posedge go) begin
      link_sel_n = 1'b0;
      #1280 link_sel_n = 1'b1;
   end
endmodule
`default_nettype wire

// ===== spi_status_flags.sv
// status word, request select and flag logic of the spi block
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module spi_status_flags (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata_r,
   // events from the shifting engine
   input  wire logic        frame_shifted,
   input  wire logic        frame_had_marker,
   input  wire logic        rx_fifo_full,
   input  wire logic        rx_shift_full,
   input  wire logic        tx_fifo_empty,
   input  wire logic        tx_fifo_full,
   // link pin from the external master
   input  wire logic        link_sel_n,
   // dma
   input  wire logic        dma_fill_ack,
   output logic             dma_fill_req,
   // interrupt
   output logic             irq
);
   ////////////////////////////////////////////////////////////////////////
   logic        sel_s1_r, sel_s2_r, sel_s3_r;
   logic [31:0] req_sel_r;
   logic [3:0]  ctrl_r;
   logic        run_r;
   logic [31:0] flags_r;
   logic [31:0] set_vec, clr_vec, status_word;
   wire         is_master  = ctrl_r[spi_status_pkg::CTRL_MASTER];
   wire         disabled   = ctrl_r[spi_status_pkg::CTRL_DISABLE];
   wire         wr_status  = wr && addr == spi_status_pkg::ADDR_STATUS;
   wire         wr_reqsel  = wr && addr == spi_status_pkg::ADDR_REQ_SELECT;
   wire         wr_ctrl    = wr && addr == spi_status_pkg::ADDR_CONTROL;
   // master starts a frame in slave mode: select falls
   wire         link_start = sel_s3_r & ~sel_s2_r & ~is_master;

   ////////////////////////////////////////////////////////////////////////
   // two-flop synchroniser, edge seen from the second stage on
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_s1_r <= 1'b1;
         sel_s2_r <= 1'b1;
         sel_s3_r <= 1'b1;
      end else begin
         sel_s1_r <= link_sel_n;
         sel_s2_r <= sel_s1_r;
         sel_s3_r <= sel_s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // set events
   always_comb begin
      set_vec = '0;
      set_vec[spi_status_pkg::BIT_FRAME_DONE] = frame_shifted;
      set_vec[spi_status_pkg::BIT_QUEUE_END] = frame_shifted & frame_had_marker & is_master;
      set_vec[spi_status_pkg::BIT_TX_UNDERRUN] = link_start & tx_fifo_empty;
      set_vec[spi_status_pkg::BIT_TX_FILL] = ~tx_fifo_full;
      // overrun on slave start or master frame shifted, with rx path full
      set_vec[spi_status_pkg::BIT_RX_OVERRUN] =
         (link_start | (frame_shifted & is_master)) & rx_fifo_full & rx_shift_full;
   end

   // only ones clear, and only when enabled
   assign clr_vec = (wr_status && !disabled) ? (wdata & spi_status_pkg::FLAG_MASK) : '0;

   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_flag
         if (spi_status_pkg::FLAG_MASK[g]) begin : g_used
            logic clr_bit;
            // dma acknowledge also clears fill request
            if (g == spi_status_pkg::BIT_TX_FILL) begin : g_ack
               assign clr_bit = clr_vec[g] | dma_fill_ack;
            end else begin : g_plain
               assign clr_bit = clr_vec[g];
            end
            sticky_flag u_flag (
               .sys_clk (sys_clk),
               .rst_n   (rst_n),
               .set     (set_vec[g]),
               .clr     (clr_bit),
               .flag_r  (flags_r[g])
            );
         end else begin : g_rsvd
            assign flags_r[g] = 1'b0;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // run state and control
   wire queue_end_set = set_vec[spi_status_pkg::BIT_QUEUE_END];
   wire run_set = wr_ctrl && wdata[spi_status_pkg::CTRL_RUN];
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r    <= 4'h0;
         req_sel_r <= spi_status_pkg::REQ_SEL_RESET;
         run_r     <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl_r <= wdata[3:0];
         if (wr_reqsel) req_sel_r <= wdata & spi_status_pkg::FLAG_MASK;
         if (queue_end_set) run_r <= 1'b0;
         else if (wr_ctrl) run_r <= wdata[spi_status_pkg::CTRL_RUN];
      end
   end

   // run state reflected at bit 30
   always_comb begin
      status_word = flags_r;
      status_word[spi_status_pkg::BIT_RUN_STATE] = run_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // read port
   wire [31:0] rd_mux =
      (addr == spi_status_pkg::ADDR_STATUS)     ? status_word :
      (addr == spi_status_pkg::ADDR_REQ_SELECT) ? req_sel_r :
      (addr == spi_status_pkg::ADDR_CONTROL)    ? {28'h000_0000, ctrl_r[3:1], run_r} :
      32'h0000_0000;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) rdata_r <= 32'h0000_0000;
      else if (rd) rdata_r <= rd_mux;
      else rdata_r <= 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // fill flag to dma when selected, others to interrupt
   wire fill_to_dma = ctrl_r[spi_status_pkg::CTRL_DMA_FILL];
   assign dma_fill_req = flags_r[spi_status_pkg::BIT_TX_FILL] & fill_to_dma
                       & req_sel_r[spi_status_pkg::BIT_TX_FILL];
   wire [31:0] irq_src = flags_r & req_sel_r;
   // frame-done gated by enable bit 31
   assign irq = irq_src[spi_status_pkg::BIT_FRAME_DONE]
              | irq_src[spi_status_pkg::BIT_QUEUE_END]
              | irq_src[spi_status_pkg::BIT_TX_UNDERRUN]
              | irq_src[spi_status_pkg::BIT_RX_OVERRUN]
              | (irq_src[spi_status_pkg::BIT_TX_FILL] & ~fill_to_dma);
   logic unused_ok;
   assign unused_ok = run_set;
endmodule
`default_nettype wire

// ===== spi_status_flags_checker.sv
// port assertions for the spi status flag block
`timescale 1ns/1ps
`default_nettype none
module spi_status_flags_checker (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic [31:0] rdata_r,
   // events and requests
   input  wire logic        frame_shifted,
   input  wire logic        tx_fifo_full,
   input  wire logic        dma_fill_ack,
   input  wire logic        dma_fill_req,
   input  wire logic        irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_idle_rdata: assert property (!$past(rd) |-> rdata_r == 32'h0)
      else $error("read data outside read");
   a_resv_zero: assert property ($past(rd) && $past(addr) == 4'h0 |->
      (rdata_r & 32'h25f7_ffff) == 32'h0) else $error("reserved bit set");
   a_unmapped_zero: assert property (rd && addr > 4'h2 |=> rdata_r == 32'h0)
      else $error("unmapped read not zero");
   a_done_seen: assert property (frame_shifted ##1 (rd && addr == 4'h0) |=> rdata_r[31])
      else $error("frame done missing");
   a_fill_seen: assert property (!tx_fifo_full ##1 (rd && addr == 4'h0) |=> rdata_r[25])
      else $error("fill flag missing");
   a_ack_clears: assert property (dma_fill_ack && tx_fifo_full |=> !dma_fill_req)
      else $error("fill request kept");
   a_zero_write: assert property (wr && addr == 4'h0 && wdata == 32'h0 && !dma_fill_ack
      |=> !$fell(irq)) else $error("zero write cleared");
   a_irq_cause: assert property ($fell(irq) |-> $past(wr) || $past(dma_fill_ack)
      || $past(tx_fifo_full)) else $error("irq dropped");
   c_frame: cover property (frame_shifted ##1 rd);
   c_ack: cover property (dma_fill_ack && dma_fill_req);
   c_irq: cover property ($rose(irq));
endmodule
bind spi_status_flags spi_status_flags_checker spi_status_flags_checker_inst (.sys_clk,
   .rst_n, .addr, .wdata, .wr, .rd, .rdata_r, .frame_shifted, .tx_fifo_full, .dma_fill_ack,
   .dma_fill_req, .irq);
`default_nettype wire

// ===== spi_status_flags_test.sv
// self-checking bench for the spi status flag block
`timescale 1ns/1ps
`default_nettype none
module spi_status_flags_test;
   logic        sys_clk = 0, rst_n = 0, wr = 0, rd = 0, fs = 0, mk = 0, rff = 0, rsf = 0;
   logic        tfe = 0, tff = 0, ack = 0, go = 0, sel_n, irq, req;
   logic [3:0]  addr = 0;
   logic [31:0] wdata = 0, rdata_r;
   int          n_fail = 0, n_compared = 0;
   always #2 sys_clk = ~sys_clk;
   spi_status_flags spi_status_flags_inst (.sys_clk, .rst_n, .addr, .wdata, .wr, .rd,
      .rdata_r, .frame_shifted(fs), .frame_had_marker(mk), .rx_fifo_full(rff),
      .rx_shift_full(rsf), .tx_fifo_empty(tfe), .tx_fifo_full(tff), .link_sel_n(sel_n),
      .dma_fill_ack(ack), .dma_fill_req(req), .irq);
   spi_link_master spi_link_master_inst (.go, .link_sel_n(sel_n));
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      wr <= 1;
      addr <= a;
      wdata <= d;
      tick(1);
      wr <= 0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      rd <= 1;
      addr <= a;
      tick(1);
      rd <= 0;
      #1 check(rdata_r, exp);
      $display("test read of %h done", a);
      tick(1);
   endtask
   task automatic frame(input logic m);
      fs <= 1;
      mk <= m;
      tick(1);
      fs <= 0;
   endtask
   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #4000 n_fail++;
      summarize();
   end
   initial begin
      tick(5);
      rst_n <= 1;
      tick(2);
      rd_chk(4'h0, 32'h0200_0000);
      fs <= 1;
      wr_reg(4'h0, 32'h8000_0000);
      fs <= 0;
      wr_reg(4'h0, 32'h0);
      rd_chk(4'h0, 32'h8200_0000);
      wr_reg(4'h0, 32'hffff_ffff);
      rd_chk(4'h0, 32'h0200_0000);
      rd_chk(4'h7, 32'h0);
      wr_reg(4'h1, 32'h8000_0000);
      frame(0);
      tick(1);
      check(irq, 1);
      wr_reg(4'h1, 32'h0);
      tick(1);
      check(irq, 0);
      wr_reg(4'h0, 32'hffff_ffff);
      wr_reg(4'h2, 32'h3);
      rd_chk(4'h0, 32'h4200_0000);
      frame(1);
      rd_chk(4'h0, 32'h9200_0000);
      rff <= 1;
      rsf <= 1;
      wr_reg(4'h0, 32'hffff_ffff);
      frame(0);
      rd_chk(4'h0, 32'h8208_0000);
      rff <= 0;
      rsf <= 0;
      wr_reg(4'h0, 32'hffff_ffff);
      wr_reg(4'h2, 32'h0);
      tfe <= 1;
      go <= 1;
      tick(8);
      rd_chk(4'h0, 32'h0a00_0000);
      wr_reg(4'h2, 32'h4);
      wr_reg(4'h0, 32'hffff_ffff);
      rd_chk(4'h0, 32'h0a00_0000);
      wr_reg(4'h2, 32'h8);
      wr_reg(4'h1, 32'h0200_0000);
      tick(1);
      check(req, 1);
      tff <= 1;
      ack <= 1;
      tick(1);
      ack <= 0;
      tick(1);
      check(req, 0);
      summarize();
   end
endmodule
`default_nettype wire

// ===== spi_status_pkg.sv
// constants for the spi status and event-flag block
//
// Contract
// - event flags stay set until software writes one to them
// - writing zero to a flag bit leaves it unchanged
// - frame-done flag, bit 31, sets when a frame has shifted out
// - run-state bit 30 reads 0 when stopped, 1 when running
// - master mode: queue-end flag bit 28 sets on end of marked entry
// - setting the queue-end flag clears the run-state bit
// - slave mode: underrun flag bit 27 sets when master starts on empty fifo
// - fill request flag bit 25 set while transmit fifo not full
// - fill request flag also cleared by dma acknowledge
// - overrun flag bit 19 sets when transfer starts with rx path full; in master mode the code sets it when a frame has shifted out
// - reserved status bits read zero and ignore writes
// - status writes ignored while the module is disabled
// - flags feed interrupt and dma request paths
// - frame-done interrupt only when its enable bit 31 is one
package spi_status_pkg;
   localparam logic [3:0]  ADDR_STATUS     = 4'h0;
   localparam logic [3:0]  ADDR_REQ_SELECT = 4'h1;
   localparam logic [3:0]  ADDR_CONTROL    = 4'h2;
   localparam int          BIT_FRAME_DONE  = 31;
   localparam int          BIT_RUN_STATE   = 30;
   localparam int          BIT_QUEUE_END   = 28;
   localparam int          BIT_TX_UNDERRUN = 27;
   localparam int          BIT_TX_FILL     = 25;
   localparam int          BIT_RX_OVERRUN  = 19;
   localparam logic [31:0] FLAG_MASK       = 32'h9a08_0000;
   localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
   localparam logic [31:0] REQ_SEL_RESET   = 32'h0000_0000;
   localparam int          CTRL_RUN        = 0;
   localparam int          CTRL_MASTER     = 1;
   localparam int          CTRL_DISABLE    = 2;
   localparam int          CTRL_DMA_FILL   = 3;
endpackage

// ===== sticky_flag.sv
// one sticky event flag with write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // set and clear
   input  wire logic set,
   input  wire logic clr,
   // state
   output logic      flag_r
);
   logic flag_nxt;
   assign flag_nxt = set | (flag_r & ~clr);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) flag_r <= 1'b0;
      else flag_r <= flag_nxt;
   end
endmodule
`default_nettype wire
